// ==== rtl/dcfc_ctrl.sv ====
// Port control and flag logic of a two-port 64 x 36 FIFO.
// Assumes both port clocks arrive as pins, each well below a quarter of core_clk_i.
`timescale 1ns/10ps
`default_nettype none
`include "dcfc_map.svh"

// What this block does
// - Port A write stores FIFO or mail.
// - Port A mailbox read sets its flag high.
// - Port B FIFO read or mail write decode.
// - Port B mailbox read sets flag high.
// - Empty drops on last byte or word.
// - Read pointer advances per new output word.
// - New word visible after three read cycles.
// - Empty rises on second read edge.
// - Late edge defers first sync cycle.
// - Full flag lives on write clock.
// - Writes ignored while full flag low.
// - Write pointer advances per accepted write.
// - Freed slot writable after three write cycles.
// - Full rises on second write edge.
// - Late edge defers first write sync cycle.
// - Almost-empty from offset, read clock synced.
// - Flags follow word count against offset.
// - Reset clears pointers and sets flag levels.
// - Reset release loads offset from picks.
// - Reads ignored while empty flag low.
module dcfc_ctrl
   import dcfc_pkg::*;
#(
   parameter int DATA_W = `DCFC_DATA_W,
   parameter int DEPTH = `DCFC_DEPTH,
   parameter int AW = `DCFC_AW
) (
   // Core clock, reset, enable
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   input wire logic clk_en_i,
   // Port A pins
   input wire logic write_side_clock_i,
   input wire logic port_a_chip_sel_n_i,
   input wire logic port_a_direction_i,
   input wire logic port_a_qualifier_i,
   input wire logic port_a_mailbox_sel_i,
   input wire logic [DATA_W-1:0] a_data_i,
   output logic [DATA_W-1:0] a_data_o,
   output logic a_data_oe_n_o,
   // Port B pins
   input wire logic read_side_clock_i,
   input wire logic port_b_chip_sel_n_i,
   input wire logic port_b_direction_i,
   input wire logic port_b_qualifier_i,
   input wire logic b_width_sel_hi_i,
   input wire logic b_width_sel_lo_i,
   input wire logic [DATA_W-1:0] b_data_i,
   output logic [DATA_W-1:0] b_data_o,
   output logic b_data_oe_n_o,
   // Offset straps
   input wire logic offset_pick_hi_i,
   input wire logic offset_pick_lo_i,
   // Flags
   output logic empty_n_flag_o,
   output logic almost_empty_n_o,
   output logic full_n_flag_o,
   output logic almost_full_n_o,
   output logic mail_to_b_flag_n_o,
   output logic mail_to_a_flag_n_o
);
   localparam int AV = DATA_W + 5;
   localparam int BV = DATA_W + 6;

   function automatic dcfc_width_type width_of(input logic hi, input logic lo);
      dcfc_width_type w;
      w = DCFC_LONG;
      case ({hi, lo})
         2'b01: w = DCFC_WORD;
         2'b10: w = DCFC_BYTE;
         default: w = DCFC_LONG;
      endcase
      return w;
   endfunction

   function automatic logic [2:0] units_of(input dcfc_width_type w);
      logic [2:0] u;
      u = `DCFC_UNITS_LONG;
      case (w)
         DCFC_WORD: u = `DCFC_UNITS_WORD;
         DCFC_BYTE: u = `DCFC_UNITS_BYTE;
         default: u = `DCFC_UNITS_LONG;
      endcase
      return u;
   endfunction

   // Unit placed in the low bits; upper bits are don't-care but driven
   function automatic logic [DATA_W-1:0] unit_sel(input logic [DATA_W-1:0] word,
                                                  input dcfc_width_type w,
                                                  input logic [1:0] idx);
      logic [DATA_W-1:0] r;
      r = word;
      case (w)
         DCFC_WORD: r = DATA_W'(word >> (idx[0] * `DCFC_WORD_W));
         DCFC_BYTE: r = DATA_W'(word >> (idx * `DCFC_BYTE_W));
         default: r = word;
      endcase
      return r;
   endfunction

   // Pin synchronisers, two stages before any logic
   logic [AV-1:0] a_s1_q;
   logic [AV-1:0] a_s2_q;
   logic a_clk_s3_q;
   logic [BV-1:0] b_s1_q;
   logic [BV-1:0] b_s2_q;
   logic b_clk_s3_q;
   logic [1:0] ofs_s1_q;
   logic [1:0] ofs_s2_q;

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         // Select seen high in reset, so the data pins stay released
         a_s1_q <= {2'b01, {(AV-2){1'b0}}};
         a_s2_q <= {2'b01, {(AV-2){1'b0}}};
         a_clk_s3_q <= 1'b0;
         b_s1_q <= {2'b01, {(BV-2){1'b0}}};
         b_s2_q <= {2'b01, {(BV-2){1'b0}}};
         b_clk_s3_q <= 1'b0;
         ofs_s1_q <= 2'h0;
         ofs_s2_q <= 2'h0;
      end else if (clk_en_i) begin
         a_s1_q <= {write_side_clock_i, port_a_chip_sel_n_i, port_a_direction_i,
                    port_a_qualifier_i, port_a_mailbox_sel_i, a_data_i};
         a_s2_q <= a_s1_q;
         a_clk_s3_q <= a_s2_q[AV-1];
         b_s1_q <= {read_side_clock_i, port_b_chip_sel_n_i, port_b_direction_i,
                    port_b_qualifier_i, b_width_sel_hi_i, b_width_sel_lo_i, b_data_i};
         b_s2_q <= b_s1_q;
         b_clk_s3_q <= b_s2_q[BV-1];
         ofs_s1_q <= {offset_pick_hi_i, offset_pick_lo_i};
         ofs_s2_q <= ofs_s1_q;
      end
   end

   wire logic a_edge = a_s2_q[AV-1] & ~a_clk_s3_q;
   wire logic a_cs_n = a_s2_q[AV-2];
   wire logic a_dir = a_s2_q[AV-3];
   wire logic a_qual = a_s2_q[AV-4];
   wire logic a_mb = a_s2_q[AV-5];
   wire logic [DATA_W-1:0] a_din = a_s2_q[DATA_W-1:0];
   wire logic b_edge = b_s2_q[BV-1] & ~b_clk_s3_q;
   wire logic b_cs_n = b_s2_q[BV-2];
   wire logic b_dir = b_s2_q[BV-3];
   wire logic b_qual = b_s2_q[BV-4];
   wire logic b_hi = b_s2_q[BV-5];
   wire logic b_lo = b_s2_q[BV-6];
   wire logic [DATA_W-1:0] b_din = b_s2_q[DATA_W-1:0];
   wire logic b_both = b_hi & b_lo;

   // Registered state
   logic full_n_q;
   logic af_n_q;
   logic empty_n_q;
   logic ae_n_q;
   logic wr_alive_q;
   logic mail_to_b_flag_n_q;
   logic mail_to_a_flag_n_q;
   logic [DATA_W-1:0] mail_to_b_q;
   logic [DATA_W-1:0] mail_to_a_q;
   // Far pointers: one copy here, the flag flop acts as the second stage
   logic [AW:0] wp_s1_q;
   logic [AW:0] rp_s1_q;
   logic [6:0] ofs_q;
   logic [1:0] ofs_cnt_q;
   logic [2:0] units_left_q;
   logic [1:0] unit_idx_q;
   dcfc_width_type held_width_q;
   logic load_q;
   logic [DATA_W-1:0] held_word_q;
   logic [DATA_W-1:0] b_fifo_out_q;

   // FIFO storage
   wire logic fifo_in_ready;
   wire logic fifo_out_valid;
   wire logic [DATA_W-1:0] fifo_out_data;
   wire logic [AW:0] wr_ptr;
   wire logic [AW:0] rd_ptr;

   // Port A decode
   wire logic a_sel = a_edge & ~a_cs_n & a_qual;
   wire logic fifo_wr_sel = a_sel & a_dir & ~a_mb;
   wire logic push = fifo_wr_sel & full_n_q & fifo_in_ready;
   wire logic mail_b_wr = a_sel & a_dir & a_mb & mail_to_b_flag_n_q;
   wire logic mail_a_rd = a_sel & ~a_dir & a_mb;

   // Port B decode
   wire logic b_sel = b_edge & ~b_cs_n & b_qual;
   wire logic fifo_rd_sel = b_sel & ~b_dir & ~b_both;
   wire logic mail_a_wr = b_sel & b_dir & b_both & mail_to_a_flag_n_q;
   wire logic mail_b_rd = b_sel & ~b_dir & b_both;
   wire logic rd_go = fifo_rd_sel & empty_n_q;

   // Bus sizing: a new long word is unloaded when the held one is used up
   wire dcfc_width_type cur_width = width_of(b_hi, b_lo);
   wire logic need_new = (units_left_q == 3'h0) | (cur_width != held_width_q);
   wire logic pop = rd_go & need_new & fifo_out_valid;
   wire logic step = rd_go & ~need_new;
   wire logic [2:0] units_left_d = pop ? 3'(units_of(cur_width) - 3'h1) :
                                   step ? 3'(units_left_q - 3'h1) : units_left_q;

   // Flag arithmetic on the far pointer seen through its first stage
   wire logic [AW:0] rd_next = rd_ptr + (AW+1)'(pop);
   wire logic [AW:0] wr_next = wr_ptr + (AW+1)'(push);
   wire logic [6:0] count_r = 7'(wp_s1_q - rd_next);
   wire logic [6:0] count_w = 7'(wr_next - rp_s1_q);
   wire logic [6:0] af_level = 7'(`DCFC_FULL_CNT - ofs_q);

   dcfc_fifo #(
      .WIDTH(DATA_W),
      .DEPTH(DEPTH),
      .AW(AW)
   ) dcfc_fifo_i (
      .core_clk_i(core_clk_i),
      .rst_n_i(rst_n_i),
      .clk_en_i(clk_en_i),
      .in_valid_i(fifo_wr_sel & full_n_q),
      .in_ready_o(fifo_in_ready),
      .in_data_i(a_din),
      .out_valid_o(fifo_out_valid),
      .out_ready_i(rd_go & need_new),
      .out_data_o(fifo_out_data),
      .wr_ptr_o(wr_ptr),
      .rd_ptr_o(rd_ptr)
   );

   // Write-side flags, updated only on write-clock edges
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rp_s1_q <= '0;
         full_n_q <= 1'b0;
         af_n_q <= 1'b1;
         wr_alive_q <= 1'b0;
      end else if (clk_en_i && a_edge) begin
         rp_s1_q <= rd_ptr;
         wr_alive_q <= 1'b1;
         // Stage-one copy equals what stage two holds after this edge
         full_n_q <= wr_alive_q & (count_w != `DCFC_FULL_CNT);
         af_n_q <= (count_w < af_level);
      end
   end

   // Read-side flags, updated only on read-clock edges
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wp_s1_q <= '0;
         empty_n_q <= 1'b0;
         ae_n_q <= 1'b0;
      end else if (clk_en_i && b_edge) begin
         wp_s1_q <= wr_ptr;
         empty_n_q <= (count_r != 7'h00) | (units_left_d != 3'h0);
         ae_n_q <= (count_r > ofs_q);
      end
   end

   // Offset capture once the straps have crossed the synchroniser
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ofs_q <= `DCFC_OFS_RST;
         ofs_cnt_q <= 2'h0;
      end else if (clk_en_i && ofs_cnt_q <= `DCFC_LOAD_DELAY) begin
         ofs_cnt_q <= ofs_cnt_q + 2'h1;
         if (ofs_cnt_q == `DCFC_LOAD_DELAY) begin
            case (ofs_s2_q)
               2'b11: ofs_q <= `DCFC_OFS_HH;
               2'b10: ofs_q <= `DCFC_OFS_HL;
               2'b01: ofs_q <= `DCFC_OFS_LH;
               default: ofs_q <= `DCFC_OFS_LL;
            endcase
         end
      end
   end

   // Mailboxes; a write is taken only while its flag is high, and then wins over a read in the same cycle
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         mail_to_b_q <= '0;
         mail_to_a_q <= '0;
         mail_to_b_flag_n_q <= 1'b1;
         mail_to_a_flag_n_q <= 1'b1;
      end else if (clk_en_i) begin
         if (mail_b_wr) begin
            mail_to_b_q <= a_din;
            mail_to_b_flag_n_q <= 1'b0;
         end else if (mail_b_rd) begin
            mail_to_b_flag_n_q <= 1'b1;
         end
         if (mail_a_wr) begin
            mail_to_a_q <= b_din;
            mail_to_a_flag_n_q <= 1'b0;
         end else if (mail_a_rd) begin
            mail_to_a_flag_n_q <= 1'b1;
         end
      end
   end

   // Port B output register and auxiliary long-word holding
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         units_left_q <= 3'h0;
         unit_idx_q <= 2'h0;
         held_width_q <= DCFC_LONG;
         load_q <= 1'b0;
         held_word_q <= '0;
         b_fifo_out_q <= '0;
      end else if (clk_en_i) begin
         units_left_q <= units_left_d;
         load_q <= pop;
         if (pop) begin
            held_width_q <= cur_width;
            unit_idx_q <= 2'h0;
         end else if (step) begin
            unit_idx_q <= unit_idx_q + 2'h1;
            b_fifo_out_q <= unit_sel(held_word_q, held_width_q, 2'(unit_idx_q + 2'h1));
         end
         // Storage read data lands one cycle after the pop
         if (load_q) begin
            held_word_q <= fifo_out_data;
            b_fifo_out_q <= unit_sel(fifo_out_data, held_width_q, 2'h0);
         end
      end
   end

   // Pins; mail data bypasses bus sizing
   assign a_data_o = mail_to_a_q;
   assign a_data_oe_n_o = a_cs_n | a_dir;
   assign b_data_o = b_both ? mail_to_b_q : b_fifo_out_q;
   assign b_data_oe_n_o = b_cs_n | b_dir;
   assign empty_n_flag_o = empty_n_q;
   assign almost_empty_n_o = ae_n_q;
   assign full_n_flag_o = full_n_q;
   assign almost_full_n_o = af_n_q;
   assign mail_to_b_flag_n_o = mail_to_b_flag_n_q;
   assign mail_to_a_flag_n_o = mail_to_a_flag_n_q;
endmodule
`default_nettype wire

// ==== rtl/dcfc_map.svh ====
// Constants of the two-port FIFO control block: sizes, offsets, counts.
// Assumes inclusion by bare name from the design files.
`ifndef DCFC_MAP_SVH
`define DCFC_MAP_SVH

`define DCFC_DATA_W 36
`define DCFC_DEPTH 64
`define DCFC_AW 6
`define DCFC_PTR_W 7
`define DCFC_FULL_CNT 7'h40
`define DCFC_OFS_HH 7'h10
`define DCFC_OFS_HL 7'h0C
`define DCFC_OFS_LH 7'h08
`define DCFC_OFS_LL 7'h04
`define DCFC_OFS_RST 7'h04
`define DCFC_LOAD_DELAY 2'h2
`define DCFC_UNITS_LONG 3'h1
`define DCFC_UNITS_WORD 3'h2
`define DCFC_UNITS_BYTE 3'h4
`define DCFC_BYTE_W 9
`define DCFC_WORD_W 18

`endif

// ==== rtl/dcfc_pkg.sv ====
// Types shared by the FIFO control block.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package dcfc_pkg;
   typedef enum logic [1:0] {
      DCFC_LONG,
      DCFC_WORD,
      DCFC_BYTE
   } dcfc_width_type;
endpackage
`default_nettype wire

// ==== rtl/dcfc_fifo.sv ====
// Storage FIFO with valid/ready on both sides and registered read data.
// Assumes DEPTH is a power of two equal to 2**AW.
`timescale 1ns/10ps
`default_nettype none
module dcfc_fifo #(
   parameter int WIDTH = 36,
   parameter int DEPTH = 32,
   parameter int AW = 5
) (
   // Clock, reset, enable
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   input wire logic clk_en_i,
   // Fill side
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   // Drain side
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o,
   // Pointers for the flag logic
   output logic [AW:0] wr_ptr_o,
   output logic [AW:0] rd_ptr_o
);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_ptr_q;
   logic [AW:0] rd_ptr_q;
   logic [WIDTH-1:0] out_data_q;
   wire logic [AW:0] used;
   wire logic push;
   wire logic pop;

   assign used = wr_ptr_q - rd_ptr_q;
   assign in_ready_o = (used != (AW+1)'(DEPTH));
   assign out_valid_o = (used != '0);
   assign push = in_valid_i & in_ready_o;
   assign pop = out_ready_i & out_valid_o;
   assign out_data_o = out_data_q;
   assign wr_ptr_o = wr_ptr_q;
   assign rd_ptr_o = rd_ptr_q;

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         out_data_q <= '0;
      end else if (clk_en_i) begin
         if (push) begin
            wr_ptr_q <= wr_ptr_q + 1'b1;
         end
         if (pop) begin
            rd_ptr_q <= rd_ptr_q + 1'b1;
            out_data_q <= mem[rd_ptr_q[AW-1:0]];
         end
      end
   end

   // Storage has no reset; contents only matter once written
   always_ff @(posedge core_clk_i) begin
      if (clk_en_i && push) begin
         mem[wr_ptr_q[AW-1:0]] <= in_data_i;
      end
   end
endmodule
`default_nettype wire

// ==== tb/dcfc_ctrl_monitor.sv ====
// Checker of dcfc_ctrl pins: flag clock domains, pin direction, reset levels.
// Assumes port clocks are slow pins sampled by core_clk_i.
`timescale 1ns/10ps
`default_nettype none
module dcfc_chk (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   // Port pins
   input wire logic write_side_clock_i,
   input wire logic read_side_clock_i,
   input wire logic port_a_chip_sel_n_i,
   input wire logic port_a_direction_i,
   input wire logic port_b_chip_sel_n_i,
   input wire logic port_b_direction_i,
   // Outputs
   input wire logic a_data_oe_n_o,
   input wire logic b_data_oe_n_o,
   input wire logic empty_n_flag_o,
   input wire logic almost_empty_n_o,
   input wire logic full_n_flag_o,
   input wire logic almost_full_n_o,
   input wire logic mail_to_b_flag_n_o,
   input wire logic mail_to_a_flag_n_o
);
   logic a_clk_q, b_clk_q;
   logic [3:0] a_age_q, a_age_d, b_age_q, b_age_d;
   // Cycles since each port clock rose, saturating so old edges never match
   assign a_age_d = (write_side_clock_i && !a_clk_q) ? 4'h0 : a_age_q + {3'h0, a_age_q != 4'hF};
   assign b_age_d = (read_side_clock_i && !b_clk_q) ? 4'h0 : b_age_q + {3'h0, b_age_q != 4'hF};
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         {a_clk_q, b_clk_q, a_age_q, b_age_q} <= {2'h0, 8'hFF};
      end else begin
         {a_clk_q, b_clk_q, a_age_q, b_age_q} <= {write_side_clock_i, read_side_clock_i, a_age_d, b_age_d};
      end
   end
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (!rst_n_i);
   sequence a_drives;
      (!port_a_chip_sel_n_i && !port_a_direction_i) [*5];
   endsequence
   sequence b_drives;
      (!port_b_chip_sel_n_i && !port_b_direction_i) [*5];
   endsequence
   sequence a_released;
      (port_a_chip_sel_n_i || port_a_direction_i) [*5];
   endsequence
   sequence b_released;
      (port_b_chip_sel_n_i || port_b_direction_i) [*5];
   endsequence
   a_float_a: assert property (a_released |-> a_data_oe_n_o)
      else $error("port A driving while released");
   b_float_a: assert property (b_released |-> b_data_oe_n_o)
      else $error("port B driving while released");
   a_drive_a: assert property (a_drives |-> !a_data_oe_n_o)
      else $error("port A not driving");
   b_drive_a: assert property (b_drives |-> !b_data_oe_n_o)
      else $error("port B not driving");
   full_dom_a: assert property ($changed(full_n_flag_o) |-> a_age_q inside {[2:8]})
      else $error("full flag off its clock");
   af_dom_a: assert property ($changed(almost_full_n_o) |-> a_age_q inside {[2:8]})
      else $error("almost full off its clock");
   ef_dom_a: assert property ($changed(empty_n_flag_o) |-> b_age_q inside {[2:8]})
      else $error("empty flag off its clock");
   ae_dom_a: assert property ($changed(almost_empty_n_o) |-> b_age_q inside {[2:8]})
      else $error("almost empty off its clock");
   ae_ef_a: assert property (almost_empty_n_o |-> empty_n_flag_o)
      else $error("almost empty without data");
   full_af_a: assert property ($fell(full_n_flag_o) |-> !almost_full_n_o)
      else $error("full without almost full");
   mb_set_a: assert property ($fell(mail_to_b_flag_n_o) |-> a_age_q inside {[2:8]})
      else $error("mail to B set off clock");
   mb_clr_a: assert property ($rose(mail_to_b_flag_n_o) |-> b_age_q inside {[2:8]})
      else $error("mail to B cleared off clock");
   ma_clr_a: assert property ($rose(mail_to_a_flag_n_o) |-> a_age_q inside {[2:8]})
      else $error("mail to A cleared off clock");
   rst_lvl_a: assert property (disable iff (1'b0) !rst_n_i |-> !empty_n_flag_o
      && !almost_empty_n_o && !full_n_flag_o && almost_full_n_o && mail_to_b_flag_n_o
      && mail_to_a_flag_n_o && a_data_oe_n_o && b_data_oe_n_o)
      else $error("reset flag levels wrong");
endmodule
bind dcfc_ctrl dcfc_chk dcfc_chk_i (.core_clk_i, .rst_n_i, .write_side_clock_i,
   .read_side_clock_i, .port_a_chip_sel_n_i, .port_a_direction_i, .port_b_chip_sel_n_i,
   .port_b_direction_i, .a_data_oe_n_o, .b_data_oe_n_o, .empty_n_flag_o, .almost_empty_n_o,
   .full_n_flag_o, .almost_full_n_o, .mail_to_b_flag_n_o, .mail_to_a_flag_n_o);
`default_nettype wire

// ==== tb/dcfc_pm.sv ====
// Model of the bus controllers at ports A and B of dcfc_ctrl.
// Assumes core_clk_i is the design's core clock; port clocks only move per access.
`timescale 1ns/10ps
`default_nettype none
module dcfc_pm (
   // Core clock
   input wire logic core_clk_i,
   // Port A: clock, {chip_sel_n, direction, qualifier, mailbox_sel}, data
   output logic a_clk_o,
   output logic [3:0] a_ctl_o,
   output logic [35:0] a_dat_o,
   // Port B: clock, {chip_sel_n, direction, qualifier, width_hi, width_lo}, data
   output logic b_clk_o,
   output logic [4:0] b_ctl_o,
   output logic [35:0] b_dat_o
);
   initial begin
      {a_clk_o, b_clk_o} = 2'h0;
      a_ctl_o = 4'h8;
      b_ctl_o = 5'h10;
      a_dat_o = 36'h0;
      b_dat_o = 36'h0;
   end
   // Controls held 4 cycles ahead and 8 after the rising port clock
   task automatic strobe_clk(input logic port_b);
      repeat (4) @(posedge core_clk_i);
      if (port_b) b_clk_o <= 1'h1;
      else a_clk_o <= 1'h1;
      repeat (4) @(posedge core_clk_i);
      if (port_b) b_clk_o <= 1'h0;
      else a_clk_o <= 1'h0;
      repeat (4) @(posedge core_clk_i);
   endtask
   task automatic a_op(input logic [3:0] ctl, input logic [35:0] dat);
      @(posedge core_clk_i);
      a_ctl_o <= ctl;
      a_dat_o <= dat;
      strobe_clk(1'h0);
      a_ctl_o[3:1] <= 3'h4;
      // Released bus shows the inverse, never a stale word
      a_dat_o <= ~dat;
   endtask
   task automatic b_op(input logic [4:0] ctl, input logic [35:0] dat);
      @(posedge core_clk_i);
      b_ctl_o <= ctl;
      b_dat_o <= dat;
      strobe_clk(1'h1);
      // Width selects kept so the output mux stays put after the access
      b_ctl_o[4:2] <= 3'h4;
      b_dat_o <= ~dat;
   endtask
endmodule
`default_nettype wire

// ==== tb/dcfc_ctrl_tb.sv ====
// Bench for dcfc_ctrl: fill and drain at every offset, unit reads, mailboxes.
// Assumes dcfc_pm drives the port pins and dcfc_chk is bound to the design.
`timescale 1ns/10ps
`default_nettype none
module dcfc_ctrl_tb;
   logic core_clk_i, rst_n_i, clk_en_i, offset_pick_hi_i, offset_pick_lo_i, a_clk, b_clk;
   logic a_data_oe_n_o, b_data_oe_n_o, empty_n_flag_o, almost_empty_n_o;
   logic full_n_flag_o, almost_full_n_o, mail_to_b_flag_n_o, mail_to_a_flag_n_o;
   logic [3:0] a_ctl, c;
   logic [4:0] b_ctl;
   logic [35:0] a_dat, b_dat, a_data_o, b_data_o, w, m, flag_now;
   logic [35:0] q[$];
   int bad_count, check_count, seed, x, u, uw;

   assign flag_now = {30'h0, empty_n_flag_o, almost_empty_n_o, almost_full_n_o,
      full_n_flag_o, mail_to_b_flag_n_o, mail_to_a_flag_n_o};
   dcfc_pm dcfc_pm_i (.core_clk_i, .a_clk_o(a_clk), .a_ctl_o(a_ctl), .a_dat_o(a_dat),
      .b_clk_o(b_clk), .b_ctl_o(b_ctl), .b_dat_o(b_dat));
   dcfc_ctrl dcfc_ctrl_i (.core_clk_i, .rst_n_i, .clk_en_i, .write_side_clock_i(a_clk),
      .port_a_chip_sel_n_i(a_ctl[3]), .port_a_direction_i(a_ctl[2]),
      .port_a_qualifier_i(a_ctl[1]), .port_a_mailbox_sel_i(a_ctl[0]), .a_data_i(a_dat),
      .a_data_o, .a_data_oe_n_o, .read_side_clock_i(b_clk), .port_b_chip_sel_n_i(b_ctl[4]),
      .port_b_direction_i(b_ctl[3]), .port_b_qualifier_i(b_ctl[2]),
      .b_width_sel_hi_i(b_ctl[1]), .b_width_sel_lo_i(b_ctl[0]), .b_data_i(b_dat), .b_data_o,
      .b_data_oe_n_o, .offset_pick_hi_i, .offset_pick_lo_i, .empty_n_flag_o, .almost_empty_n_o,
      .full_n_flag_o, .almost_full_n_o, .mail_to_b_flag_n_o, .mail_to_a_flag_n_o);

   task automatic chk(input logic [35:0] got, input logic [35:0] exp);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   function automatic logic [35:0] rnd();
      return {4'($random(seed)), 32'($random(seed))};
   endfunction
   // Flags expected for n stored words, mail flags idle
   function automatic logic [35:0] flags(input int n);
      return {30'h0, n != 0, n > x, n < 64 - x, n < 64, 2'h3};
   endfunction
   // Two edges of each port clock let both flag pairs catch up
   task automatic settle(input int n);
      repeat (2) dcfc_pm_i.a_op(4'h8, rnd());
      repeat (2) dcfc_pm_i.b_op(5'h10, rnd());
      chk(flag_now, flags(n));
   endtask

   initial begin
      core_clk_i = 1'h0;
      forever #5 core_clk_i = ~core_clk_i;
   end
   initial begin
      repeat (90000) @(posedge core_clk_i);
      bad_count++;
      $display("mismatch at %0t: run hung", $time);
      give_verdict();
   end
   initial begin
      seed = 12094;
      bad_count = 0;
      check_count = 0;
      // High at time zero so reset starts with a clean falling edge
      rst_n_i = 1'h1;
      clk_en_i = 1'h1;
      {offset_pick_hi_i, offset_pick_lo_i} = 2'h0;
      for (int p = 0; p < 4; p++) begin
         @(posedge core_clk_i);
         rst_n_i <= 1'h0;
         {offset_pick_hi_i, offset_pick_lo_i} <= 2'(p);
         repeat (8) @(posedge core_clk_i);
         rst_n_i <= 1'h1;
         x = 4 * (p + 1);
         repeat (4) @(posedge core_clk_i);
         chk(flag_now, 36'h0B);
         settle(0);
         for (int n = 1; n <= 64; n++) begin
            c = 4'($random(seed));
            // Junk access that must not store anything
            if (c[3:1] == 3'h3) c[3] = 1'h1;
            if (c[0]) dcfc_pm_i.a_op(c, rnd());
            w = rnd();
            dcfc_pm_i.a_op(4'h6, w);
            q.push_back(w);
            settle(n);
         end
         dcfc_pm_i.a_op(4'h6, rnd());
         settle(64);
         for (int n = 63; n >= 0; n--) begin
            dcfc_pm_i.b_op(5'h04, rnd());
            chk(b_data_o, q.pop_front());
            settle(n);
         end
         w = b_data_o;
         dcfc_pm_i.b_op(5'h04, rnd());
         chk(b_data_o, w);
         chk(flag_now, flags(0));
         $display("offset %0d fill and drain done", x);
      end
      for (u = 2; u <= 4; u += 2) begin
         w = rnd();
         uw = 36 / u;
         m = (36'h1 << uw) - 36'h1;
         dcfc_pm_i.a_op(4'h6, w);
         settle(1);
         for (int k = 0; k < u; k++) begin
            dcfc_pm_i.b_op(u == 2 ? 5'h05 : 5'h06, rnd());
            chk(b_data_o & m, (w >> (k * uw)) & m);
            chk(36'(empty_n_flag_o), 36'(k < u - 1));
         end
         $display("unit reads of %0d done", u);
      end
      w = rnd();
      dcfc_pm_i.a_op(4'h7, w);
      dcfc_pm_i.a_op(4'h7, ~w);
      chk(36'(mail_to_b_flag_n_o), 36'h0);
      dcfc_pm_i.b_op(5'h07, rnd());
      chk(b_data_o, w);
      chk(36'(mail_to_b_flag_n_o), 36'h1);
      w = rnd();
      dcfc_pm_i.b_op(5'h0F, w);
      chk(36'(mail_to_a_flag_n_o), 36'h0);
      dcfc_pm_i.a_op(4'h3, rnd());
      chk(a_data_o, w);
      chk(36'(mail_to_a_flag_n_o), 36'h1);
      $display("mailbox test done");
      // Frozen core must miss a mail write that would otherwise land
      repeat (4) @(posedge core_clk_i);
      clk_en_i <= 1'h0;
      dcfc_pm_i.b_op(5'h0F, ~w);
      clk_en_i <= 1'h1;
      repeat (4) @(posedge core_clk_i);
      chk(36'(mail_to_a_flag_n_o), 36'h1);
      chk(a_data_o, w);
      $display("clock enable test done");
      give_verdict();
   end
endmodule
`default_nettype wire
